// ---- common/swb_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the bus timer
`ifndef SWB_CFG_SVH
`define SWB_CFG_SVH

// Clock and time base
`define SWB_CLK_HZ 20000000
`define SWB_US_PER_S 1000000
`define SWB_CYC_PER_US (`SWB_CLK_HZ / `SWB_US_PER_S)

// Register byte offsets
`define SWB_OFS_CMD 8'h00
`define SWB_OFS_SPEED 8'h04
`define SWB_OFS_CFG_CMD 8'h08
`define SWB_OFS_CFG_RESP 8'h0c
`define SWB_OFS_STATUS 8'h10
`define SWB_OFS_RESP 8'h14

// Field positions
`define SWB_CMD_OP_MSB 9
`define SWB_CMD_OP_LSB 8
`define SWB_STAT_BUSY 0
`define SWB_STAT_VALID 1
`define SWB_RESP_VALID 8

// Segment lengths in microseconds
`define SWB_RST_LOW_STD_US 512
`define SWB_RST_LOW_OD_US 64
`define SWB_SI_STD_US 8
`define SWB_SI_OD_US 2
`define SWB_PDT_STD_US 64
`define SWB_PDT_OD_US 8
`define SWB_FILL_STD_US 512
`define SWB_FILL_OD_US 64
`define SWB_SHORT_WAIT_US 4096
`define SWB_W1_LOW_STD_US 8
`define SWB_W1_LOW_OD_US 1
`define SWB_DSO_STD_US 3
`define SWB_DSO_OD_US 1
`define SWB_HIGH1_STD_US 49
`define SWB_HIGH1_OD_US 8
`define SWB_LOW0_STD_US 57
`define SWB_LOW0_OD_US 7
`define SWB_REC0_US 3

// Configuration parameter codes and reset values
`define SWB_PAR_SLEW 3'h1
`define SWB_PAR_W1LT 3'h4
`define SWB_PAR_DSO 3'h5
`define SWB_SLEW_DEFAULT 3'h0
`define SWB_PPD_DEFAULT 3'h4
`define SWB_SPUD_DEFAULT 3'h4
`define SWB_PAR_DEF_OTHER 3'h0

// Reset result codes and response framing
`define SWB_RES_SHORT 2'h0
`define SWB_RES_PRESENCE 2'h1
`define SWB_RES_ALARM 2'h2
`define SWB_RES_NONE 2'h3
`define SWB_RST_RESP_HI 6'h33

// Bus answers
`define SWB_AXI_OKAY 2'h0
`define SWB_AXI_SLVERR 2'h2

`endif

// ---- common/swb_pkg.sv ----
// Types shared by the bus timing block
package swb_pkg;

  typedef enum logic [10:0] {
    ST_IDLE = 11'h001,
    ST_PREP = 11'h002,
    ST_RST_LOW = 11'h004,
    ST_SI = 11'h008,
    ST_SHORT_WAIT = 11'h010,
    ST_PDT = 11'h020,
    ST_FILL = 11'h040,
    ST_SLOT_LOW = 11'h080,
    ST_DSO = 11'h100,
    ST_SLOT_HIGH = 11'h200,
    ST_DONE = 11'h400
  } swb_state_type;

  typedef enum logic [1:0] {
    SWB_SPD_STD = 2'h0,
    SWB_SPD_FLEX = 2'h1,
    SWB_SPD_OD = 2'h2
  } swb_speed_type;

  typedef enum logic [1:0] {
    SWB_OP_NONE = 2'h0,
    SWB_OP_RESET = 2'h1,
    SWB_OP_BYTE = 2'h2,
    SWB_OP_BIT = 2'h3
  } swb_op_type;

endpackage

// ---- logic/swb_sync2.sv ----
// Two flip-flop synchroniser for the bus level
`timescale 1ns/1ns
module swb_sync2 (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Asynchronous level in, synchronised level out
  input wire logic d,
  output logic q
);
  logic meta_reg;

  // First stage is read only by the second; bus idles high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 1'b1;
      q <= 1'b1;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // swb_sync2

// ---- logic/swb_us_tick.sv ----
// Restartable microsecond enable pulse
`timescale 1ns/1ns
module swb_us_tick #(
  parameter int DIV = 20
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Phase restart and tick out
  input wire logic restart,
  output logic tick
);
  logic [7:0] cnt_reg;
  logic wrap;

  // Restart aligns the tick to a segment start, so segments are exact
  assign wrap = (cnt_reg == 8'(DIV - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      cnt_reg <= 8'h00;
      tick <= 1'b0;
    end else begin
      cnt_reg <= wrap ? 8'h00 : cnt_reg + 8'h01;
      tick <= (cnt_reg == 8'(DIV - 2));
    end
  end
endmodule // swb_us_tick

// ---- logic/swb_bus_timing.sv ----
// Single wire bus timing generator with AXI4-Lite register access
// Function
// - Weak pullup switches off one cycle before the pulldown turns on.
// - Falling slew is default except at flexible speed, then parameter one.
// - Reset drives bus low 512us, or 64us at overdrive.
// - After release wait 8us, or 2us overdrive, then sample short.
// - High sample then waits 64us, or 8us overdrive, sampling presence.
// - After presence sample wait fill 512us or 64us, then respond.
// - Whole reset high interval uses only the weak pullup.
// - Low sample waits 4096us, samples again; still low reports short.
// - Second sample high waits fill, reports alarm, no presence sample.
// - Short and interrupt detection runs identically at overdrive.
// - Write-one slot: low, sample offset, read sample, high time.
// - Write-zero slot is low then recovery, with no bus sample.
// - Slots inside a byte follow each other with no idle time.
// - Response is posted as soon as the final slot completes.
// - Reset segments are the same at standard and flexible speed.
// - Config byte: bit7 clear, bit0 set, code 6:4, value 3:1.
// - Config response bit0 clear; write echoes, read returns value.
`timescale 1ns/1ns
`include "swb_cfg.svh"
module swb_bus_timing
  import swb_pkg::*;
#(
  parameter int AW = 8,
  parameter int RST_LOW_STD_US = `SWB_RST_LOW_STD_US,
  parameter int FILL_STD_US = `SWB_FILL_STD_US,
  parameter int SHORT_WAIT_US = `SWB_SHORT_WAIT_US
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Open-drain bus pin and pullup control
  input wire logic bus_in,
  output logic bus_out,
  output logic bus_oe,
  output logic weak_pullup_current,
  output logic [2:0] pulldown_slew_param
);
  localparam int CYC_US = `SWB_CYC_PER_US;

  swb_state_type state_reg, state_next;
  logic [1:0] speed_reg;
  swb_op_type op_reg;
  logic [12:0] timer_reg, timer_next;
  logic [7:0] shift_reg;
  logic [3:0] bits_left_reg;
  logic rx_bit_reg, alarm_reg;
  logic [1:0] result_reg;
  logic [7:0] resp_reg, cfg_resp_reg;
  logic resp_valid_reg;
  logic [2:0] param_reg [0:7];
  logic aw_full_reg, w_full_reg;
  logic [AW-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [31:0] rd_mux;
  logic bus_s, us_tick, seg_load;

  // Only word addresses of the six registers answer OKAY
  function automatic logic is_mapped(input logic [AW-1:0] a);
    logic [7:0] b;
    b = 8'(a);
    return (b == `SWB_OFS_CMD) || (b == `SWB_OFS_SPEED) ||
           (b == `SWB_OFS_CFG_CMD) || (b == `SWB_OFS_CFG_RESP) ||
           (b == `SWB_OFS_STATUS) || (b == `SWB_OFS_RESP);
  endfunction

  function automatic logic [2:0] par_default(input int idx);
    logic [2:0] v;
    v = `SWB_PAR_DEF_OTHER;
    case (idx)
      1: v = `SWB_SLEW_DEFAULT;
      2: v = `SWB_PPD_DEFAULT;
      3: v = `SWB_SPUD_DEFAULT;
      default: v = `SWB_PAR_DEF_OTHER;
    endcase
    return v;
  endfunction

  // Segment length in microseconds for the state being entered
  function automatic logic [12:0] seg_len(input swb_state_type st,
      input logic [1:0] spd, input logic b, input logic [2:0] w1,
      input logic [2:0] ds);
    logic od, fx;
    logic [12:0] n;
    od = (spd == SWB_SPD_OD);
    fx = (spd == SWB_SPD_FLEX);
    n = 13'h0001;
    case (st)
      ST_RST_LOW: n = od ? 13'(`SWB_RST_LOW_OD_US) : 13'(RST_LOW_STD_US);
      ST_SI: n = od ? 13'(`SWB_SI_OD_US) : 13'(`SWB_SI_STD_US);
      ST_SHORT_WAIT: n = 13'(SHORT_WAIT_US);
      ST_PDT: n = od ? 13'(`SWB_PDT_OD_US) : 13'(`SWB_PDT_STD_US);
      ST_FILL: n = od ? 13'(`SWB_FILL_OD_US) : 13'(FILL_STD_US);
      ST_SLOT_LOW: begin
        if (b) begin
          n = od ? 13'(`SWB_W1_LOW_OD_US) :
              13'(`SWB_W1_LOW_STD_US) + (fx ? {10'h000, w1} : 13'h0000);
        end else begin
          n = od ? 13'(`SWB_LOW0_OD_US) : 13'(`SWB_LOW0_STD_US);
        end
      end
      ST_DSO: n = od ? 13'(`SWB_DSO_OD_US) :
          13'(`SWB_DSO_STD_US) + (fx ? {10'h000, ds} : 13'h0000);
      ST_SLOT_HIGH: begin
        if (b) begin
          n = od ? 13'(`SWB_HIGH1_OD_US) : 13'(`SWB_HIGH1_STD_US);
        end else begin
          n = 13'(`SWB_REC0_US) + (fx ? {10'h000, ds} : 13'h0000);
        end
      end
      default: n = 13'h0001;
    endcase
    return n;
  endfunction

  // Pin level enters through two flops before any decision reads it
  swb_sync2 u_bus_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(bus_in),
    .q(bus_s)
  );

  // Time base restarts on every segment change
  swb_us_tick #(.DIV(CYC_US)) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .restart(seg_load),
    .tick(us_tick)
  );

  // Bus handshakes and decoded write strobes
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
  wire [7:0] wa = 8'(awaddr_reg);
  wire [7:0] ra = 8'(s_axi_araddr);
  wire cmd_wr = do_write && (wa == `SWB_OFS_CMD) && (wstrb_reg[1:0] == 2'h3);
  wire spd_wr = do_write && (wa == `SWB_OFS_SPEED) && wstrb_reg[0] &&
                (wdata_reg[1:0] != 2'h3);
  wire cfg_wr = do_write && (wa == `SWB_OFS_CFG_CMD) && wstrb_reg[0] &&
                !wdata_reg[7] && wdata_reg[0];
  wire [2:0] par_code = wdata_reg[6:4];
  wire par_we = cfg_wr && (par_code != 3'h0);
  wire rd_resp = ar_hs && (ra == `SWB_OFS_RESP);
  wire [1:0] cmd_op = wdata_reg[`SWB_CMD_OP_MSB:`SWB_CMD_OP_LSB];
  wire start = cmd_wr && (state_reg == ST_IDLE) && (cmd_op != SWB_OP_NONE);

  // Next values of the bus channel flags
  wire aw_full_next = (aw_full_reg || aw_hs) && !do_write;
  wire w_full_next = (w_full_reg || w_hs) && !do_write;
  wire bvalid_next = do_write || (s_axi_bvalid && !s_axi_bready);
  wire rvalid_next = ar_hs || (s_axi_rvalid && !s_axi_rready);

  // Write side: address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SWB_AXI_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      if (aw_hs) awaddr_reg <= s_axi_awaddr;
      if (w_hs) wdata_reg <= s_axi_wdata;
      if (w_hs) wstrb_reg <= s_axi_wstrb;
      s_axi_awready <= !aw_full_next && !bvalid_next;
      s_axi_wready <= !w_full_next && !bvalid_next;
      s_axi_bvalid <= bvalid_next;
      if (do_write) begin
        s_axi_bresp <= is_mapped(awaddr_reg) ? `SWB_AXI_OKAY :
                       `SWB_AXI_SLVERR;
      end
    end
  end

  // Read mux; write-only registers read as zero
  always_comb begin
    rd_mux = 32'h00000000;
    if (ra == `SWB_OFS_SPEED) begin
      rd_mux = {30'h0, speed_reg};
    end else if (ra == `SWB_OFS_CFG_RESP) begin
      rd_mux = {24'h0, cfg_resp_reg};
    end else if (ra == `SWB_OFS_STATUS) begin
      rd_mux = {28'h0, result_reg, resp_valid_reg, state_reg != ST_IDLE};
    end else if (ra == `SWB_OFS_RESP) begin
      rd_mux = {23'h0, resp_valid_reg, resp_reg};
    end
  end

  // Read side: one outstanding read, data held until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SWB_AXI_OKAY;
    end else begin
      s_axi_arready <= !rvalid_next;
      s_axi_rvalid <= rvalid_next;
      if (ar_hs) begin
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= is_mapped(s_axi_araddr) ? `SWB_AXI_OKAY :
                       `SWB_AXI_SLVERR;
      end
    end
  end

  // Parameter store; reset returns every code to its default
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_par
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          param_reg[gi] <= par_default(gi);
        end else if (par_we && (par_code == 3'(gi))) begin
          param_reg[gi] <= wdata_reg[3:1];
        end
      end
    end
  endgenerate

  // Config answer: echo on write, value code on read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_resp_reg <= 8'h00;
      speed_reg <= SWB_SPD_STD;
    end else begin
      if (par_we) begin
        cfg_resp_reg <= {wdata_reg[7:1], 1'b0};
      end else if (cfg_wr) begin
        cfg_resp_reg <= {wdata_reg[7:4], param_reg[wdata_reg[3:1]],
                         1'b0};
      end
      if (spd_wr) speed_reg <= wdata_reg[1:0];
    end
  end

  // Segment sequencer; every wait ends on a time-base tick
  wire expire = us_tick && (timer_reg == 13'h0001);
  assign seg_load = (state_next != state_reg);
  wire cur_bit = shift_reg[0];

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (start) state_next = ST_PREP;
      ST_PREP: state_next = (op_reg == SWB_OP_RESET) ? ST_RST_LOW :
                            ST_SLOT_LOW;
      ST_RST_LOW: if (expire) state_next = ST_SI;
      ST_SI: if (expire) begin
        state_next = bus_s ? ST_PDT : ST_SHORT_WAIT;
      end
      ST_SHORT_WAIT: if (expire) begin
        state_next = bus_s ? ST_FILL : ST_DONE;
      end
      ST_PDT: if (expire) state_next = ST_FILL;
      ST_FILL: if (expire) state_next = ST_DONE;
      ST_SLOT_LOW: if (expire) begin
        state_next = cur_bit ? ST_DSO : ST_SLOT_HIGH;
      end
      ST_DSO: if (expire) state_next = ST_SLOT_HIGH;
      ST_SLOT_HIGH: if (expire) begin
        state_next = (bits_left_reg > 4'h1) ? ST_PREP : ST_DONE;
      end
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // Timer reloads from speed and parameters when a segment begins
  always_comb begin
    timer_next = timer_reg;
    if (seg_load) begin
      timer_next = seg_len(state_next, speed_reg, cur_bit,
                           param_reg[`SWB_PAR_W1LT],
                           param_reg[`SWB_PAR_DSO]);
    end else if (us_tick && (timer_reg != 13'h0000)) begin
      timer_next = timer_reg - 13'h0001;
    end
  end

  // Sequencer state, shift data and results
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      timer_reg <= 13'h0000;
      op_reg <= SWB_OP_NONE;
      shift_reg <= 8'h00;
      bits_left_reg <= 4'h0;
      rx_bit_reg <= 1'b0;
      alarm_reg <= 1'b0;
      result_reg <= `SWB_RES_NONE;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      if (start) begin
        op_reg <= swb_op_type'(cmd_op);
        shift_reg <= wdata_reg[7:0];
        bits_left_reg <= (cmd_op == SWB_OP_BYTE) ? 4'h8 : 4'h1;
        alarm_reg <= 1'b0;
      end
      // Write-zero slots never visit the sample point
      if (state_reg == ST_SLOT_LOW && expire) rx_bit_reg <= 1'b0;
      if (state_reg == ST_DSO && expire) rx_bit_reg <= bus_s;
      if (state_reg == ST_SLOT_HIGH && expire) begin
        shift_reg <= {rx_bit_reg, shift_reg[7:1]};
        bits_left_reg <= bits_left_reg - 4'h1;
      end
      if (state_reg == ST_SHORT_WAIT && expire) begin
        alarm_reg <= bus_s;
        if (!bus_s) result_reg <= `SWB_RES_SHORT;
      end
      if (state_reg == ST_PDT && expire) begin
        result_reg <= bus_s ? `SWB_RES_NONE : `SWB_RES_PRESENCE;
      end
      if (state_reg == ST_FILL && expire && alarm_reg) begin
        result_reg <= `SWB_RES_ALARM;
      end
    end
  end

  // Response posting; a new response beats a same-cycle read clear
  wire resp_set = (state_reg == ST_DONE);
  wire [7:0] resp_byte = (op_reg == SWB_OP_RESET) ?
      {`SWB_RST_RESP_HI, result_reg} :
      (op_reg == SWB_OP_BYTE) ? shift_reg : {7'h00, shift_reg[7]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resp_reg <= 8'h00;
      resp_valid_reg <= 1'b0;
    end else begin
      if (resp_set) resp_reg <= resp_byte;
      resp_valid_reg <= resp_set || (resp_valid_reg && !rd_resp);
    end
  end

  // Pin drivers follow the next state so they line up with it
  wire low_next = (state_next == ST_RST_LOW) || (state_next == ST_SLOT_LOW);
  wire pu_off_next = low_next || (state_next == ST_PREP);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_out <= 1'b0;
      bus_oe <= 1'b0;
      weak_pullup_current <= 1'b1;
      pulldown_slew_param <= `SWB_SLEW_DEFAULT;
    end else begin
      bus_out <= 1'b0;
      bus_oe <= low_next;
      weak_pullup_current <= !pu_off_next;
      pulldown_slew_param <= (speed_reg == SWB_SPD_FLEX) ?
          param_reg[`SWB_PAR_SLEW] : `SWB_SLEW_DEFAULT;
    end
  end

  // Cycles spent in the current state, for the checks below
  logic [17:0] st_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn || seg_load) st_cnt <= 18'h00000;
    else st_cnt <= st_cnt + 18'h00001;
  end

  a_pullup_off_low: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(bus_oe) |-> !weak_pullup_current && !$past(weak_pullup_current))
    else $error("pulldown on while weak pullup active");
  a_slew_fixed: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(speed_reg) != SWB_SPD_FLEX) |->
    pulldown_slew_param == `SWB_SLEW_DEFAULT)
    else $error("slew changed outside flexible speed");
  a_rst_low_len: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_RST_LOW && expire && speed_reg != SWB_SPD_OD) |->
    st_cnt == 18'(RST_LOW_STD_US * CYC_US - 1))
    else $error("reset low time wrong");
  a_si_len: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_SI && expire && speed_reg == SWB_SPD_OD) |->
    st_cnt == 18'(`SWB_SI_OD_US * CYC_US - 1))
    else $error("short sample offset wrong");
  a_fill_len: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_FILL && expire && speed_reg != SWB_SPD_OD) |->
    st_cnt == 18'(FILL_STD_US * CYC_US - 1))
    else $error("fill delay wrong");
  a_high_weak_only: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg inside {ST_SI, ST_SHORT_WAIT, ST_PDT, ST_FILL}) |->
    weak_pullup_current && !bus_oe)
    else $error("bus driven in reset high time");
  a_short_report: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_SHORT_WAIT && expire && !bus_s) |=> ##1
    resp_valid_reg && resp_reg[1:0] == `SWB_RES_SHORT)
    else $error("short not reported at once");
  a_alarm_fill: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_SHORT_WAIT && expire && bus_s) |=>
    state_reg == ST_FILL && alarm_reg)
    else $error("alarm path skipped fill");
  a_w0_no_sample: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_DSO) |-> cur_bit)
    else $error("sample taken in write-zero slot");
  a_zero_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_SLOT_HIGH && expire && bits_left_reg > 4'h1) |=>
    state_reg == ST_PREP ##1 state_reg == ST_SLOT_LOW && bus_oe)
    else $error("idle gap between slots");
  a_resp_prompt: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_SLOT_HIGH && expire && bits_left_reg == 4'h1) |=>
    ##1 resp_valid_reg)
    else $error("response late after last slot");
  a_cfg_bit0: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_wr |=> cfg_resp_reg[0] == 1'b0 &&
    cfg_resp_reg[7:4] == $past(wdata_reg[7:4]))
    else $error("config response malformed");

  c_reset_presence: cover property (@(posedge aclk) disable iff (!aresetn)
    resp_set && op_reg == SWB_OP_RESET &&
    result_reg == `SWB_RES_PRESENCE);
  c_reset_short: cover property (@(posedge aclk) disable iff (!aresetn)
    resp_set && result_reg == `SWB_RES_SHORT);
  c_byte_done: cover property (@(posedge aclk) disable iff (!aresetn)
    resp_set && op_reg == SWB_OP_BYTE);
  c_flex_slew: cover property (@(posedge aclk) disable iff (!aresetn)
    bus_oe && pulldown_slew_param != `SWB_SLEW_DEFAULT);
endmodule // swb_bus_timing

// ---- verification/swb_slave_model.sv ----
// Behavioural slave device hanging on the open-drain bus
`timescale 1ns/1ns
module swb_slave_model (
  // Master pulldown enable
  input wire logic bus_oe,
  // Answer behaviour: 0 none, 1 presence, 2 alarm, 3 short
  input wire logic [1:0] mode,
  input wire logic [7:0] rd_byte,
  // Slave pulldown, bus pulled up when low
  output logic pull_low
);
  time t0;
  logic [2:0] idx;
  time dur;
  // A zero is answered by holding the slot low past the read sample
  initial begin
    pull_low = 1'b0;
    idx = 3'h0;
    forever begin
      @(posedge bus_oe);
      t0 = $time;
      if (!rd_byte[idx]) fork
        begin
          pull_low = 1'b1;
          #15000 pull_low = 1'b0;
        end
      join_none
      idx++;
      @(negedge bus_oe);
      // Anything low for more than 60us, past a write-zero low phase, is a bus reset
      if ($time - t0 > 60000 && mode != 2'h0) begin
        idx = 3'h0;
        dur = (mode == 2'h1) ? 60000 : (mode == 2'h2) ? 20000 : 45000;
        if (mode == 2'h1) #20000;
        pull_low = 1'b1;
        #(dur) pull_low = 1'b0;
      end else if ($time - t0 > 60000) idx = 3'h0;
    end
  end
endmodule // swb_slave_model

// ---- verification/swb_bus_timing_tb.sv ----
// Bench for the bus timing block: register tasks and bus scenarios
`timescale 1ns/1ns
`include "swb_cfg.svh"
module swb_bus_timing_tb;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, bus_out, bus_oe, pull;
  logic weak_pullup_current;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrsp, brsp, mode = 2'h0;
  logic [2:0] pulldown_slew_param;
  logic [7:0] rd_byte = 8'h5a;
  logic [1:0] res [4] = '{`SWB_RES_NONE, `SWB_RES_PRESENCE,
    `SWB_RES_ALARM, `SWB_RES_SHORT};
  int err_total = 0, num_checks = 0, cyc = 0, lo_cnt = 0;
  // Open-drain level: low if either party pulls
  wire bus_in = !(pull | (bus_oe & !bus_out));

  swb_bus_timing #(.RST_LOW_STD_US(80), .FILL_STD_US(16),
    .SHORT_WAIT_US(32)) uut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus_in,
    .bus_out, .bus_oe, .weak_pullup_current, .pulldown_slew_param);
  swb_slave_model slave (.bus_oe(bus_oe), .mode(mode),
    .rd_byte(rd_byte), .pull_low(pull));

  // 20 MHz clock, reset held three cycles
  initial forever #25 aclk = ~aclk;
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
  end

  // Cycle ceiling, master low time and pullup watch
  always @(posedge aclk) begin
    cyc++;
    if (bus_oe) lo_cnt++;
    if (bus_oe && weak_pullup_current !== 1'b0) chk(32'h1, 32'h0);
    // Open drain: the data level itself must never go high
    if (bus_out !== 1'b0) chk(32'h1, 32'h0);
    if (cyc == 60000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    brsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Start an operation, poll busy, then compare the response word
  task automatic run_op(input logic [31:0] cmd, input logic [31:0] exp);
    lo_cnt = 0;
    wr(`SWB_OFS_CMD, cmd);
    do rd(`SWB_OFS_STATUS, rdata, rrsp); while (rdata[0] !== 1'b0);
    rd(`SWB_OFS_RESP, rdata, rrsp);
    chk(rdata, exp);
    repeat (1200) @(posedge aclk);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    @(posedge aresetn);
    @(posedge aclk);
    chk(32'({weak_pullup_current, bus_oe, pulldown_slew_param}), 32'h10);
    // Every reset outcome at standard speed
    for (int m = 0; m < 4; m++) begin
      mode <= m[1:0];
      run_op(32'h100, {24'h1, `SWB_RST_RESP_HI, res[m]});
      chk(32'(lo_cnt), 32'd1600);
    end
    run_op(32'h2ff, {24'h1, rd_byte});
    chk(32'(lo_cnt), 32'd1280);
    run_op(32'h2c3, {24'h1, 8'hc3 & rd_byte});
    chk(32'(lo_cnt), 32'd5200);
    run_op(32'h301, 32'h100);
    // Slew code, parameter readback and an unmapped address
    wr(`SWB_OFS_CFG_CMD, 32'h19);
    chk(32'(brsp), 32'(`SWB_AXI_OKAY));
    rd(`SWB_OFS_CFG_RESP, rdata, rrsp);
    chk(rdata, 32'h18);
    chk(32'(pulldown_slew_param), 32'h0);
    wr(`SWB_OFS_SPEED, 32'h1);
    // Slew output follows the speed register one edge later
    @(negedge aclk);
    chk(32'(pulldown_slew_param), 32'h4);
    wr(`SWB_OFS_CFG_CMD, 32'h03);
    rd(`SWB_OFS_CFG_RESP, rdata, rrsp);
    chk(rdata, 32'h08);
    rd(8'h20, rdata, rrsp);
    chk({rdata[29:0], rrsp}, 32'(`SWB_AXI_SLVERR));
    wr(8'h20, 32'h0);
    chk(32'(brsp), 32'(`SWB_AXI_SLVERR));
    mode <= 2'h1;
    run_op(32'h100, {24'h1, `SWB_RST_RESP_HI, `SWB_RES_PRESENCE});
    chk(32'(lo_cnt), 32'd1600);
    // Flexible slot: 10us low plus 4us offset stays inside the answer
    wr(`SWB_OFS_CFG_CMD, 32'h45);
    wr(`SWB_OFS_CFG_CMD, 32'h53);
    run_op(32'h301, 32'h100);
    chk(32'(lo_cnt), 32'd200);
    // Overdrive keeps the interrupt test
    wr(`SWB_OFS_SPEED, 32'h2);
    @(negedge aclk);
    chk(32'(pulldown_slew_param), 32'h0);
    mode <= 2'h2;
    run_op(32'h100, {24'h1, `SWB_RST_RESP_HI, `SWB_RES_ALARM});
    chk(32'(lo_cnt), 32'd1280);
    finish_test();
  end
endmodule // swb_bus_timing_tb
